// ### logic/crs_register_set.sv
`timescale 1ns/1ps
`default_nettype none
module crs_register_set (
	input wire logic clk_in,
	input wire logic rst_n_in,
	// General register access from the datapath
	input wire logic gpr_wr_en_in,
	input wire logic [2:0] gpr_wr_idx_in,
	input wire crs_pkg::crs_size_e gpr_wr_size_in,
	input wire logic gpr_wr_hi_byte_in,
	input wire logic [31:0] gpr_wr_data_in,
	input wire logic [2:0] gpr_rd_idx_in,
	input wire crs_pkg::crs_size_e gpr_rd_size_in,
	input wire logic gpr_rd_hi_byte_in,
	output logic [31:0] gpr_rd_data_out,
	input wire logic sp_wr_en_in,
	input wire logic [31:0] sp_wr_data_in,
	output logic [31:0] stack_pointer_reg_out,
	// Program counter
	input wire logic pc_load_in,
	input wire logic [23:0] pc_load_data_in,
	input wire logic pc_advance_in,
	output logic [23:0] next_instr_counter_out,
	output logic [23:0] fetch_addr_out,
	// Control register instructions
	input wire crs_pkg::crs_ctl_e flags_ctl_op_in,
	input wire crs_pkg::crs_ctl_e exc_ctl_op_in,
	input wire logic [7:0] ctl_operand_in,
	output logic [7:0] condition_flags_out,
	output logic [7:0] extended_control_out,
	// Exception entry
	input wire logic exception_start_in,
	// Arithmetic result flag update
	input wire logic alu_flags_en_in,
	input wire crs_pkg::crs_size_e alu_size_in,
	input wire logic [31:0] alu_result_in,
	input wire logic alu_half_carry_in,
	input wire logic alu_hc_en_in,
	input wire logic alu_overflow_in,
	input wire logic alu_ovf_en_in,
	input wire logic alu_carry_in,
	input wire logic alu_carry_en_in,
	// Bit accumulator write into the carry flag
	input wire logic bit_acc_en_in,
	input wire logic bit_acc_value_in,
	// Interrupt acceptance
	input wire logic irq_pending_in,
	input wire logic nmi_pending_in,
	output logic irq_accept_out,
	output logic nmi_accept_out,
	// Branch condition evaluation
	input wire crs_pkg::crs_cond_e branch_cond_in,
	output logic branch_taken_out
);
	logic [23:0] pc_reg;
	logic [7:0] flags_reg;
	logic [7:0] flags_next;
	logic [7:0] exc_reg;
	logic [7:0] exc_next;
	logic res_neg;
	logic res_zero;
	logic half_sel;
	logic flag_n;
	logic flag_z;
	logic flag_v;
	logic flag_c;

	crs_gpr_if gpr ();

	assign gpr.wr_en = gpr_wr_en_in;
	assign gpr.wr_idx = gpr_wr_idx_in;
	assign gpr.wr_size = gpr_wr_size_in;
	assign gpr.wr_hi_byte = gpr_wr_hi_byte_in;
	assign gpr.wr_data = gpr_wr_data_in;
	assign gpr.rd_idx = gpr_rd_idx_in;
	assign gpr.rd_size = gpr_rd_size_in;
	assign gpr.rd_hi_byte = gpr_rd_hi_byte_in;
	assign gpr.sp_wr_en = sp_wr_en_in;
	assign gpr.sp_wr_data = sp_wr_data_in;
	assign gpr_rd_data_out = gpr.rd_data;
	assign stack_pointer_reg_out = gpr.sp_value;

	crs_gpr_bank #(
		.COUNT(crs_pkg::GPR_COUNT)
	) u_bank (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.gpr(gpr)
	);

	// Program counter; reset value comes later from the vector fetch
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			pc_reg <= 24'h0;
		else if (pc_load_in)
			pc_reg <= pc_load_data_in;
		else if (pc_advance_in)
			pc_reg <= pc_reg + 24'h2;
	end

	assign next_instr_counter_out = pc_reg;
	assign fetch_addr_out = {pc_reg[23:1], 1'b0};

	// Result sign and zero at the operand width
	always_comb
	begin
		res_neg = alu_result_in[31];
		res_zero = (alu_result_in == 32'h0);
		half_sel = alu_half_carry_in;
		unique case (alu_size_in)
			crs_pkg::CRS_SZ_BYTE:
			begin
				res_neg = alu_result_in[7];
				res_zero = (alu_result_in[7:0] == 8'h0);
			end
			crs_pkg::CRS_SZ_LOWER, crs_pkg::CRS_SZ_UPPER:
			begin
				res_neg = alu_result_in[15];
				res_zero = (alu_result_in[15:0] == 16'h0);
			end
			crs_pkg::CRS_SZ_LONG:
			begin
				res_neg = alu_result_in[31];
				res_zero = (alu_result_in == 32'h0);
			end
			default:
			begin
				res_neg = alu_result_in[31];
				res_zero = (alu_result_in == 32'h0);
			end
		endcase
	end

	// Control ops take priority over the ALU so software sees its own write
	always_comb
	begin
		flags_next = flags_reg;
		unique case (flags_ctl_op_in)
			crs_pkg::CRS_CTL_LOAD: flags_next = ctl_operand_in;
			crs_pkg::CRS_CTL_AND: flags_next = flags_reg & ctl_operand_in;
			crs_pkg::CRS_CTL_OR: flags_next = flags_reg | ctl_operand_in;
			crs_pkg::CRS_CTL_XOR: flags_next = flags_reg ^ ctl_operand_in;
			crs_pkg::CRS_CTL_NONE:
			begin
				if (alu_flags_en_in)
				begin
					flags_next[crs_pkg::CF_NEG_BIT] = res_neg;
					flags_next[crs_pkg::CF_ZERO_BIT] = res_zero;
					if (alu_hc_en_in)
						flags_next[crs_pkg::CF_HALF_BIT] = half_sel;
					if (alu_ovf_en_in)
						flags_next[crs_pkg::CF_OVF_BIT] = alu_overflow_in;
					if (alu_carry_en_in)
						flags_next[crs_pkg::CF_CARRY_BIT] = alu_carry_in;
				end
				if (bit_acc_en_in)
					flags_next[crs_pkg::CF_CARRY_BIT] = bit_acc_value_in;
			end
			default: flags_next = flags_reg;
		endcase
		// Exception entry always leaves the mask set, whatever else happened
		if (exception_start_in)
			flags_next[crs_pkg::CF_MASK_BIT] = 1'b1;
	end

	// Only the mask bit has a defined reset; the rest reset to zero here
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			flags_reg <= crs_pkg::CF_RESET;
		else
			flags_reg <= flags_next;
	end

	assign condition_flags_out = flags_reg;

	always_comb
	begin
		exc_next = exc_reg;
		unique case (exc_ctl_op_in)
			crs_pkg::CRS_CTL_LOAD: exc_next = ctl_operand_in;
			crs_pkg::CRS_CTL_AND: exc_next = exc_reg & ctl_operand_in;
			crs_pkg::CRS_CTL_OR: exc_next = exc_reg | ctl_operand_in;
			crs_pkg::CRS_CTL_XOR: exc_next = exc_reg ^ ctl_operand_in;
			crs_pkg::CRS_CTL_NONE: exc_next = exc_reg;
			default: exc_next = exc_reg;
		endcase
		exc_next = (exc_next & crs_pkg::EXC_RW_MASK)
			| crs_pkg::EXC_RSVD_MASK;
	end

	// Trace and mask level are stored only; nothing in the core reads them
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			exc_reg <= crs_pkg::EXC_RESET;
		else
			exc_reg <= exc_next;
	end

	assign extended_control_out = exc_reg | crs_pkg::EXC_RSVD_MASK;

	// Maskable interrupt gating from the mask bit; the non-maskable request is not gated
	assign irq_accept_out = irq_pending_in
		& ~flags_reg[crs_pkg::CF_MASK_BIT];
	assign nmi_accept_out = nmi_pending_in;

	assign flag_n = flags_reg[crs_pkg::CF_NEG_BIT];
	assign flag_z = flags_reg[crs_pkg::CF_ZERO_BIT];
	assign flag_v = flags_reg[crs_pkg::CF_OVF_BIT];
	assign flag_c = flags_reg[crs_pkg::CF_CARRY_BIT];

	always_comb
	begin
		unique case (branch_cond_in)
			crs_pkg::CRS_BR_ALWAYS: branch_taken_out = 1'b1;
			crs_pkg::CRS_BR_NEVER: branch_taken_out = 1'b0;
			crs_pkg::CRS_BR_HI: branch_taken_out = ~(flag_c | flag_z);
			crs_pkg::CRS_BR_LS: branch_taken_out = flag_c | flag_z;
			crs_pkg::CRS_BR_CC: branch_taken_out = ~flag_c;
			crs_pkg::CRS_BR_CS: branch_taken_out = flag_c;
			crs_pkg::CRS_BR_NE: branch_taken_out = ~flag_z;
			crs_pkg::CRS_BR_EQ: branch_taken_out = flag_z;
			crs_pkg::CRS_BR_VC: branch_taken_out = ~flag_v;
			crs_pkg::CRS_BR_VS: branch_taken_out = flag_v;
			crs_pkg::CRS_BR_PL: branch_taken_out = ~flag_n;
			crs_pkg::CRS_BR_MI: branch_taken_out = flag_n;
			crs_pkg::CRS_BR_GE: branch_taken_out = ~(flag_n ^ flag_v);
			crs_pkg::CRS_BR_LT: branch_taken_out = flag_n ^ flag_v;
			crs_pkg::CRS_BR_GT: branch_taken_out = ~(flag_z | (flag_n ^ flag_v));
			crs_pkg::CRS_BR_LE: branch_taken_out = flag_z | (flag_n ^ flag_v);
		endcase
	end
endmodule // crs_register_set
`default_nettype wire

// ### include/crs_pkg.sv
package crs_pkg;
	localparam int GPR_COUNT = 8;
	localparam int GPR_WIDTH = 32;
	localparam int GPR_IDX_W = 3;
	localparam int PC_WIDTH = 24;
	localparam logic [2:0] SP_INDEX = 3'h7;

	// Access width of a general register view
	typedef enum logic [3:0] {
		CRS_SZ_LONG = 4'h1,
		CRS_SZ_UPPER = 4'h2,
		CRS_SZ_LOWER = 4'h4,
		CRS_SZ_BYTE = 4'h8
	} crs_size_e;

	// Control instruction operations on a control register
	typedef enum logic [4:0] {
		CRS_CTL_NONE = 5'h01,
		CRS_CTL_LOAD = 5'h02,
		CRS_CTL_AND = 5'h04,
		CRS_CTL_OR = 5'h08,
		CRS_CTL_XOR = 5'h10
	} crs_ctl_e;

	// Extended control field layout
	localparam int EXC_TRACE_BIT = 7;
	localparam logic [7:0] EXC_RSVD_MASK = 8'h78;
	localparam logic [7:0] EXC_RW_MASK = 8'h87;
	localparam logic [7:0] EXC_RESET = 8'h7f;

	// Condition flag field layout
	localparam int CF_MASK_BIT = 7;
	localparam int CF_USER_BIT = 6;
	localparam int CF_HALF_BIT = 5;
	localparam int CF_USER2_BIT = 4;
	localparam int CF_NEG_BIT = 3;
	localparam int CF_ZERO_BIT = 2;
	localparam int CF_OVF_BIT = 1;
	localparam int CF_CARRY_BIT = 0;
	localparam logic [7:0] CF_RESET = 8'h80;

	// Half-carry tap positions per operand size
	localparam int HC_BYTE_BIT = 3;
	localparam int HC_WORD_BIT = 11;
	localparam int HC_LONG_BIT = 27;

	// Branch condition codes
	typedef enum logic [3:0] {
		CRS_BR_ALWAYS = 4'h0,
		CRS_BR_NEVER = 4'h1,
		CRS_BR_HI = 4'h2,
		CRS_BR_LS = 4'h3,
		CRS_BR_CC = 4'h4,
		CRS_BR_CS = 4'h5,
		CRS_BR_NE = 4'h6,
		CRS_BR_EQ = 4'h7,
		CRS_BR_VC = 4'h8,
		CRS_BR_VS = 4'h9,
		CRS_BR_PL = 4'ha,
		CRS_BR_MI = 4'hb,
		CRS_BR_GE = 4'hc,
		CRS_BR_LT = 4'hd,
		CRS_BR_GT = 4'he,
		CRS_BR_LE = 4'hf
	} crs_cond_e;
endpackage

// ### include/crs_gpr_if.sv
`timescale 1ns/1ps
`default_nettype none
interface crs_gpr_if;
	logic wr_en;
	logic [2:0] wr_idx;
	crs_pkg::crs_size_e wr_size;
	logic wr_hi_byte;
	logic [31:0] wr_data;
	logic [2:0] rd_idx;
	crs_pkg::crs_size_e rd_size;
	logic rd_hi_byte;
	logic [31:0] rd_data;
	logic sp_wr_en;
	logic [31:0] sp_wr_data;
	logic [31:0] sp_value;
	modport bank (
		input wr_en, wr_idx, wr_size, wr_hi_byte, wr_data,
		input rd_idx, rd_size, rd_hi_byte, sp_wr_en, sp_wr_data,
		output rd_data, sp_value
	);
	modport user (
		output wr_en, wr_idx, wr_size, wr_hi_byte, wr_data,
		output rd_idx, rd_size, rd_hi_byte, sp_wr_en, sp_wr_data,
		input rd_data, sp_value
	);
endinterface
`default_nettype wire

// ### logic/crs_gpr_bank.sv
`timescale 1ns/1ps
`default_nettype none
module crs_gpr_bank #(
	parameter int COUNT = crs_pkg::GPR_COUNT
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	crs_gpr_if.bank gpr
);
	// General registers are cleared to zero by reset; zero keeps sim clean
	logic [31:0] gpr_full_word [COUNT];
	logic [31:0] rd_word;
	logic [31:0] merged;

	// Byte lanes touched by a write, per view width
	always_comb
	begin
		merged = gpr_full_word[gpr.wr_idx];
		unique case (gpr.wr_size)
			crs_pkg::CRS_SZ_LONG: merged = gpr.wr_data;
			crs_pkg::CRS_SZ_UPPER: merged[31:16] = gpr.wr_data[15:0];
			crs_pkg::CRS_SZ_LOWER: merged[15:0] = gpr.wr_data[15:0];
			crs_pkg::CRS_SZ_BYTE:
			begin
				if (gpr.wr_hi_byte)
					merged[15:8] = gpr.wr_data[7:0];
				else
					merged[7:0] = gpr.wr_data[7:0];
			end
			default: merged = gpr_full_word[gpr.wr_idx];
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			for (int i = 0; i < COUNT; i++)
				gpr_full_word[i] <= 32'h0;
		end
		else
		begin
			if (gpr.wr_en)
				gpr_full_word[gpr.wr_idx] <= merged;
			// Implicit stack update wins over an operand write to the same reg
			if (gpr.sp_wr_en)
				gpr_full_word[crs_pkg::SP_INDEX] <= gpr.sp_wr_data;
		end
	end

	always_comb
	begin
		rd_word = gpr_full_word[gpr.rd_idx];
		unique case (gpr.rd_size)
			crs_pkg::CRS_SZ_LONG: gpr.rd_data = rd_word;
			crs_pkg::CRS_SZ_UPPER: gpr.rd_data = {16'h0, rd_word[31:16]};
			crs_pkg::CRS_SZ_LOWER: gpr.rd_data = {16'h0, rd_word[15:0]};
			crs_pkg::CRS_SZ_BYTE: gpr.rd_data = gpr.rd_hi_byte ?
				{24'h0, rd_word[15:8]} : {24'h0, rd_word[7:0]};
			default: gpr.rd_data = rd_word;
		endcase
	end

	assign gpr.sp_value = gpr_full_word[crs_pkg::SP_INDEX];
endmodule // crs_gpr_bank
`default_nettype wire

// ### verif/crs_register_set_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module crs_register_set_checker (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic sp_wr_en_in,
	input wire logic [31:0] sp_wr_data_in,
	input wire logic [31:0] stack_pointer_reg_out,
	input wire logic pc_load_in,
	input wire logic [23:0] pc_load_data_in,
	input wire logic pc_advance_in,
	input wire logic [23:0] next_instr_counter_out,
	input wire logic [23:0] fetch_addr_out,
	input wire crs_pkg::crs_ctl_e flags_ctl_op_in,
	input wire logic [7:0] ctl_operand_in,
	input wire logic [7:0] condition_flags_out,
	input wire logic [7:0] extended_control_out,
	input wire logic exception_start_in,
	input wire logic irq_pending_in,
	input wire logic nmi_pending_in,
	input wire logic irq_accept_out,
	input wire logic nmi_accept_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	chk_exc_sets_mask: assert property (exception_start_in |=> condition_flags_out[7])
		else $error("mask bit not set after exception start");
	chk_fetch_even: assert property (fetch_addr_out == {next_instr_counter_out[23:1], 1'b0})
		else $error("fetch address not even");
	chk_rsvd_ones: assert property (extended_control_out[6:3] == 4'hf)
		else $error("reserved control bits not ones");
	chk_irq_gate: assert property (irq_accept_out == (irq_pending_in && !condition_flags_out[7]))
		else $error("maskable request gating wrong");
	chk_nmi_pass: assert property (nmi_accept_out == nmi_pending_in)
		else $error("non-maskable request not accepted");
	chk_pc_load: assert property (pc_load_in |=> next_instr_counter_out == $past(pc_load_data_in))
		else $error("counter load lost");
	chk_pc_step: assert property (pc_advance_in && !pc_load_in |=> next_instr_counter_out == $past(next_instr_counter_out) + 24'h2)
		else $error("counter did not step by two");
	chk_sp_write: assert property (sp_wr_en_in |=> stack_pointer_reg_out == $past(sp_wr_data_in))
		else $error("stack pointer write lost");
	chk_flag_load: assert property (flags_ctl_op_in == crs_pkg::CRS_CTL_LOAD && !exception_start_in |=> condition_flags_out == $past(ctl_operand_in))
		else $error("flag load wrong");
	cover property (exception_start_in && flags_ctl_op_in == crs_pkg::CRS_CTL_LOAD);
	cover property (irq_accept_out);
	cover property (pc_load_in && pc_advance_in);
endmodule // crs_register_set_checker
bind crs_register_set crs_register_set_checker u_chk (.*);
`default_nettype wire

// ### verif/crs_alu_model.sv
`timescale 1ns/1ps
`default_nettype none
// Only adds are modelled; the register set derives N and Z from the result and stores the other flags it is handed
module crs_alu_model (
	input wire logic [31:0] a_in,
	input wire logic [31:0] b_in,
	input wire crs_pkg::crs_size_e size_in,
	output logic [31:0] result_out,
	output logic half_carry_out,
	output logic carry_out,
	output logic overflow_out
);
	logic [32:0] sum;
	logic [31:0] m;
	int w;
	always_comb
	begin
		w = size_in == crs_pkg::CRS_SZ_LONG ? 32 : size_in == crs_pkg::CRS_SZ_BYTE ? 8 : 16;
		m = 32'hffffffff >> (32 - w);
		sum = {1'b0, a_in & m} + {1'b0, b_in & m};
		result_out = sum[31:0] & m;
		carry_out = sum[w];
		half_carry_out = (((a_in & (m >> 4)) + (b_in & (m >> 4))) >> (w - 4)) != 0;
		overflow_out = a_in[w - 1] == b_in[w - 1] && sum[w - 1] != a_in[w - 1];
	end
endmodule // crs_alu_model
`default_nettype wire

// ### verif/crs_register_set_bench.sv
`timescale 1ns/1ps
`default_nettype none
module crs_register_set_bench;
	logic clk_in = 0, rst_n_in = 0, gpr_wr_en_in = 0, gpr_wr_hi_byte_in = 0;
	logic gpr_rd_hi_byte_in = 0, sp_wr_en_in = 0, pc_load_in = 0;
	logic [2:0] gpr_wr_idx_in = 0, gpr_rd_idx_in = 0;
	crs_pkg::crs_size_e gpr_wr_size_in = crs_pkg::CRS_SZ_LONG;
	crs_pkg::crs_size_e gpr_rd_size_in = crs_pkg::CRS_SZ_LONG;
	crs_pkg::crs_size_e alu_size_in = crs_pkg::CRS_SZ_LONG;
	logic [31:0] gpr_wr_data_in = 0, sp_wr_data_in = 0, alu_a = 0, alu_b = 0;
	logic [31:0] gpr_rd_data_out, stack_pointer_reg_out, alu_result_in;
	logic pc_advance_in = 0, exception_start_in = 0, alu_flags_en_in = 0;
	logic [23:0] pc_load_data_in = 0, next_instr_counter_out, fetch_addr_out;
	crs_pkg::crs_ctl_e flags_ctl_op_in = crs_pkg::CRS_CTL_NONE;
	crs_pkg::crs_ctl_e exc_ctl_op_in = crs_pkg::CRS_CTL_NONE;
	logic [7:0] ctl_operand_in = 0, condition_flags_out, extended_control_out;
	logic alu_half_carry_in, alu_overflow_in, alu_carry_in, branch_taken_out;
	logic alu_hc_en_in = 1, alu_ovf_en_in = 1, alu_carry_en_in = 1;
	logic bit_acc_en_in = 0, bit_acc_value_in = 0, irq_pending_in = 0;
	logic nmi_pending_in = 0, irq_accept_out, nmi_accept_out;
	crs_pkg::crs_cond_e branch_cond_in = crs_pkg::CRS_BR_ALWAYS;
	logic [31:0] gm [8];
	logic [7:0] fl, ex;
	int seed = 93889, fails = 0, check_count = 0;
	crs_register_set DUT (.*);
	crs_alu_model u_alu (.a_in(alu_a), .b_in(alu_b), .size_in(alu_size_in),
		.result_out(alu_result_in), .half_carry_out(alu_half_carry_in),
		.carry_out(alu_carry_in), .overflow_out(alu_overflow_in));
	always #20 clk_in = ~clk_in;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic end_sim;
		$display("checks=%0d fails=%0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	function automatic logic [31:0] view(input logic [31:0] w,
		input crs_pkg::crs_size_e s, input logic h);
		case (s)
			crs_pkg::CRS_SZ_LONG: return w;
			crs_pkg::CRS_SZ_UPPER: return {16'h0, w[31:16]};
			crs_pkg::CRS_SZ_LOWER: return {16'h0, w[15:0]};
			default: return {24'h0, h ? w[15:8] : w[7:0]};
		endcase
	endfunction
	function automatic logic [31:0] merge(input logic [31:0] o,
		input logic [31:0] d, input crs_pkg::crs_size_e s, input logic h);
		case (s)
			crs_pkg::CRS_SZ_LONG: return d;
			crs_pkg::CRS_SZ_UPPER: return {d[15:0], o[15:0]};
			crs_pkg::CRS_SZ_LOWER: return {o[31:16], d[15:0]};
			default: return h ? {o[31:16], d[7:0], o[7:0]} : {o[31:8], d[7:0]};
		endcase
	endfunction
	function automatic logic [7:0] cop(input crs_pkg::crs_ctl_e op,
		input logic [7:0] o, input logic [7:0] v);
		case (op)
			crs_pkg::CRS_CTL_LOAD: return v;
			crs_pkg::CRS_CTL_AND: return o & v;
			crs_pkg::CRS_CTL_OR: return o | v;
			crs_pkg::CRS_CTL_XOR: return o ^ v;
			default: return o;
		endcase
	endfunction
	// Codes come in pairs, the odd one being the inverse of the even one
	function automatic logic bt(input int c, input logic [7:0] f);
		logic n, z, v, cy, r;
		{n, z, v, cy} = f[3:0];
		case (c / 2)
			0: r = 1;
			1: r = !(cy | z);
			2: r = !cy;
			3: r = !z;
			4: r = !v;
			5: r = !n;
			6: r = n == v;
			default: r = !z && n == v;
		endcase
		return c[0] ? !r : r;
	endfunction
	task automatic gpr_wr(input logic [2:0] i, input crs_pkg::crs_size_e s,
		input logic h, input logic [31:0] d);
		@(posedge clk_in);
		gpr_wr_en_in <= 1;
		gpr_wr_idx_in <= i;
		gpr_wr_size_in <= s;
		gpr_wr_hi_byte_in <= h;
		gpr_wr_data_in <= d;
		gm[i] = merge(gm[i], d, s, h);
		@(posedge clk_in);
		gpr_wr_en_in <= 0;
		gpr_rd_idx_in <= i;
		gpr_rd_size_in <= s;
		gpr_rd_hi_byte_in <= h;
		#1;
		chk(gpr_rd_data_out, view(gm[i], s, h));
		chk(stack_pointer_reg_out, gm[7]);
	endtask
	task automatic probe;
		for (int c = 0; c < 16; c++)
		begin
			@(posedge clk_in);
			branch_cond_in <= crs_pkg::crs_cond_e'(c[3:0]);
			irq_pending_in <= c[0];
			nmi_pending_in <= c[1];
			#1;
			chk(branch_taken_out, bt(c, fl));
			chk(irq_accept_out, c[0] & ~fl[7]);
			chk(nmi_accept_out, c[1]);
		end
	endtask
	task automatic ctl(input int k, input logic [7:0] v, input logic x);
		crs_pkg::crs_ctl_e op;
		op = crs_pkg::crs_ctl_e'(5'h1 << k);
		@(posedge clk_in);
		flags_ctl_op_in <= op;
		exc_ctl_op_in <= op;
		ctl_operand_in <= v;
		exception_start_in <= x;
		fl = cop(op, fl, v) | {x, 7'h0};
		ex = cop(op, ex, v) & 8'h87 | 8'h78;
		@(posedge clk_in);
		flags_ctl_op_in <= crs_pkg::CRS_CTL_NONE;
		exc_ctl_op_in <= crs_pkg::CRS_CTL_NONE;
		exception_start_in <= 0;
		#1;
		chk(condition_flags_out, fl);
		chk(extended_control_out, ex);
		probe();
	endtask
	task automatic alu(input int k, input logic [31:0] a, input logic [31:0] b,
		input logic e, input logic bv);
		logic [31:0] r;
		@(posedge clk_in);
		alu_size_in <= crs_pkg::crs_size_e'(4'h1 << k);
		alu_a <= a;
		alu_b <= b;
		alu_flags_en_in <= 1;
		bit_acc_en_in <= e;
		bit_acc_value_in <= bv;
		#1;
		r = alu_result_in & (k == 0 ? 32'hffffffff : k == 3 ? 32'hff : 32'hffff);
		fl[5] = alu_half_carry_in;
		fl[3] = k == 0 ? r[31] : k == 3 ? r[7] : r[15];
		fl[2:0] = {r == 0, alu_overflow_in, e ? bv : alu_carry_in};
		@(posedge clk_in);
		alu_flags_en_in <= 0;
		bit_acc_en_in <= 0;
		#1;
		chk(condition_flags_out, fl);
	endtask
	task automatic pc(input logic [23:0] d);
		@(posedge clk_in);
		pc_load_in <= 1;
		pc_advance_in <= 1;
		pc_load_data_in <= d;
		@(posedge clk_in);
		pc_load_in <= 0;
		#1;
		chk(next_instr_counter_out, d);
		chk(fetch_addr_out, d & 24'hfffffe);
		@(posedge clk_in);
		pc_advance_in <= 0;
		#1;
		chk(next_instr_counter_out, 32'(24'(d + 24'h2)));
	endtask
	initial
	begin
		#400000;
		fails++;
		end_sim();
	end
	initial
	begin
		int r;
		for (int i = 0; i < 8; i++)
			gm[i] = 0;
		fl = 8'h80;
		ex = 8'h7f;
		repeat (20) @(posedge clk_in);
		rst_n_in <= 1;
		#1;
		chk(condition_flags_out, fl);
		chk(extended_control_out, ex);
		chk(next_instr_counter_out, 0);
		for (int i = 0; i < 8; i++)
			gpr_wr(i[2:0], crs_pkg::CRS_SZ_LONG, 0, $random(seed));
		for (int i = 0; i < 80; i++)
		begin
			r = $random(seed);
			gpr_wr(r[2:0], crs_pkg::crs_size_e'(4'h1 << r[5:4]), r[6], $random(seed));
		end
		for (int i = 0; i < 8; i++)
			gpr_wr(i[2:0], crs_pkg::CRS_SZ_UPPER, 0, gm[i][31:16]);
		r = $random(seed);
		@(posedge clk_in);
		sp_wr_en_in <= 1;
		sp_wr_data_in <= r;
		gpr_wr_en_in <= 1;
		gpr_wr_idx_in <= 3'h7;
		gpr_wr_size_in <= crs_pkg::CRS_SZ_LONG;
		gpr_wr_data_in <= ~r;
		@(posedge clk_in);
		sp_wr_en_in <= 0;
		gpr_wr_en_in <= 0;
		#1;
		chk(stack_pointer_reg_out, r);
		gm[7] = r;
		ctl(1, 8'hff, 0);
		ctl(1, 8'h00, 0);
		ctl(1, 8'h00, 1);
		for (int i = 0; i < 24; i++)
			ctl($unsigned($random(seed)) % 5, $random(seed), i % 7 == 3);
		alu(3, 32'h0f, 32'h1, 0, 0);
		alu(2, 32'hffff, 32'h1, 0, 0);
		alu(0, 32'h7fffffff, 32'h1, 1, 1);
		alu(0, 32'h0fffffff, 32'h1, 0, 0);
		for (int i = 0; i < 40; i++)
		begin
			r = $random(seed);
			alu(r[1:0] == 1 ? 2 : r[1:0], $random(seed), $random(seed), r[2], r[3]);
		end
		pc(24'habcdef);
		pc(24'hfffffe);
		r = $random(seed);
		pc(r[23:0]);
		end_sim();
	end
endmodule // crs_register_set_bench
`default_nettype wire
